/* File: hdl/spi_eeprom_command_protect.v */
// Serial EEPROM slave: opcode decode, status register, array read/write, protection.
// Assumes SPI pins arrive asynchronously and are oversampled by ref_clk_i.
`timescale 1ns/1ps
`include "eeprom_cmd_defines.vh"

// Functional notes
// - Frames start at select fall, MSB first
// - Decode set, clear latch and status read
// - Decode status write, array read, write
// - Write latch cleared at power-up
// - Clear-latch command ignores protect pin
// - Status bit 1 shows write latch
// - Status bit 0 shows busy
// - Bits 4-6 zero; all ones while busy
// - Block-guard bits select protected range
// - Guard bits change via latched write cycle
// - Pin low with enable blocks status write
// - Guarded array writes always rejected
// - Enable bit sticks while pin low
// - Read ignores input, shifts byte out
// - Read address increments and wraps
// - Busy ignores all but status read
// - Programming starts at select rise
// - Page write wraps six low bits
// - Write cycle end clears latch
// - Unlatched write discarded until next frame
// - Fourteen address bits, upper ignored
// - Unknown opcode: ignore until next frame
// - Pause pin freezes transfer, output off
// - Deselected: no input, output off
// - Pin fall with enable aborts pending status write
module spi_eeprom_command_protect #(
  parameter WC_CYCLES = `WC_CYCLES
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  input wire hold_n_i,
  input wire wp_n_i,
  output reg so_o,
  output reg so_oe_o
);

  localparam [2:0] S_OP = 3'h0;
  localparam [2:0] S_ADH = 3'h1;
  localparam [2:0] S_ADL = 3'h2;
  localparam [2:0] S_RD = 3'h3;
  localparam [2:0] S_WR = 3'h4;
  localparam [2:0] S_SRD = 3'h5;
  localparam [2:0] S_SWR = 3'h6;
  localparam [2:0] S_IGN = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: 0 cs_n, 1 sck, 2 si, 3 hold_n, 4 wp_n
  wire [4:0] pin_in;
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  reg [4:0] sync3_r;
  reg [4:0] lvl_r;
  wire [4:0] lvl_nxt;

  assign pin_in = {wp_n_i, hold_n_i, si_i, sck_i, cs_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      assign lvl_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi] : lvl_r[gi];
      always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
          sync3_r[gi] <= 1'b1;
          lvl_r[gi] <= 1'b1;
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          lvl_r[gi] <= lvl_nxt[gi];
        end
      end
    end
  endgenerate

  wire cs_fall = lvl_r[0] & ~lvl_nxt[0];
  wire cs_rise = ~lvl_r[0] & lvl_nxt[0];
  wire active = ~lvl_nxt[0] & ~lvl_r[0] & lvl_nxt[3];
  wire sck_rise = active & ~lvl_r[1] & lvl_nxt[1];
  wire sck_fall = active & lvl_r[1] & ~lvl_nxt[1];
  wire si_lvl = lvl_nxt[2];
  wire hold_lvl = lvl_nxt[3];
  wire wp_n_lvl = lvl_r[4];

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function [2:0] op_decode;
    input [7:0] op;
    begin
      op_decode = `OP_INVALID;
      if (op[7:4] == `OP_HI_NIBBLE) begin
        case (op[2:0])
          `OP_SET_WL, `OP_CLR_WL, `OP_STAT_RD, `OP_STAT_WR, `OP_ARR_RD, `OP_ARR_WR: op_decode = op[2:0];
          default: op_decode = `OP_INVALID;
        endcase
      end
    end
  endfunction

  function guarded;
    input [1:0] bg;
    input [`ADDR_W-1:0] a;
    begin
      case (bg)
        2'h1: guarded = (a[`ADDR_W-1:`ADDR_W-2] == 2'h3);
        2'h2: guarded = a[`ADDR_W-1];
        2'h3: guarded = 1'b1;
        default: guarded = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg [7:0] mem [0:`MEM_DEPTH-1];
  reg [7:0] pbuf [0:`PAGE_BYTES-1];
  reg [`PAGE_BYTES-1:0] pvalid_r;
  reg [2:0] st_r;
  reg [2:0] cnt_r;
  reg [6:0] sr_r;
  reg [7:0] tx_r;
  reg [`ADDR_W-1:0] addr_r;
  reg is_wr_r;
  reg got_r;
  reg abort_r;
  reg wel_r;
  reg [1:0] bg_r;
  reg ppe_r;
  reg [7:0] new_stat_r;
  reg busy_r;
  reg kind_stat_r;
  reg [31:0] timer_r;
  reg [6:0] idx_r;

  wire [7:0] rx_byte = {sr_r, si_lvl};
  wire byte_done = sck_rise & (cnt_r == 3'h7);
  wire [2:0] cmd = op_decode(rx_byte);
  wire [7:0] status = busy_r ? `ST_BUSY_VALUE : {ppe_r, 3'h0, bg_r, wel_r, 1'b0};
  wire [`ADDR_W-1:0] full_addr = {addr_r[`ADDR_W-1:8], rx_byte};
  wire [5:0] pofs = addr_r[5:0];
  wire [`ADDR_W-1:0] prog_addr = {addr_r[`ADDR_W-1:6], idx_r[5:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Array programming, one buffered byte per cycle at cycle start
  always @(posedge ref_clk_i) begin
    if (busy_r && !kind_stat_r && !idx_r[6] && pvalid_r[idx_r[5:0]])
      mem[prog_addr] <= pbuf[idx_r[5:0]];
  end

  always @(posedge ref_clk_i) begin
    if (byte_done && st_r == S_WR)
      pbuf[pofs] <= rx_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine, protection and write cycle
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= S_IGN;
      cnt_r <= 3'h0;
      sr_r <= 7'h00;
      tx_r <= 8'h00;
      addr_r <= {`ADDR_W{1'b0}};
      is_wr_r <= 1'b0;
      got_r <= 1'b0;
      abort_r <= 1'b0;
      wel_r <= 1'b0;
      bg_r <= `RST_BG;
      ppe_r <= `RST_PPE;
      new_stat_r <= 8'h00;
      busy_r <= 1'b0;
      kind_stat_r <= 1'b0;
      timer_r <= 32'h0;
      idx_r <= 7'h00;
      pvalid_r <= {`PAGE_BYTES{1'b0}};
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else begin
      so_oe_o <= active & hold_lvl & (st_r == S_RD || st_r == S_SRD);
      if (busy_r) begin
        timer_r <= timer_r + 32'h1;
        if (!idx_r[6])
          idx_r <= idx_r + 7'h1;
        if (timer_r >= WC_CYCLES - 1) begin
          busy_r <= 1'b0;
          wel_r <= 1'b0;
          if (kind_stat_r) begin
            bg_r <= {new_stat_r[`ST_BG_HI_BIT], new_stat_r[`ST_BG_LO_BIT]};
            ppe_r <= new_stat_r[`ST_PPE_BIT];
          end
        end
      end
      if (cs_fall) begin
        st_r <= S_OP;
        cnt_r <= 3'h0;
        got_r <= 1'b0;
        abort_r <= 1'b0;
      end else if (cs_rise) begin
        st_r <= S_IGN;
        if (cnt_r == 3'h0 && got_r && !busy_r) begin
          if (st_r == S_WR && |pvalid_r) begin
            busy_r <= 1'b1;
            kind_stat_r <= 1'b0;
            timer_r <= 32'h0;
            idx_r <= 7'h00;
          end else if (st_r == S_SWR && !abort_r && !(!wp_n_lvl && ppe_r)) begin
            busy_r <= 1'b1;
            kind_stat_r <= 1'b1;
            timer_r <= 32'h0;
          end
        end
      end else begin
        if (st_r == S_SWR && !wp_n_lvl && ppe_r)
          abort_r <= 1'b1;
        if (sck_rise && st_r != S_IGN) begin
          sr_r <= rx_byte[6:0];
          cnt_r <= cnt_r + 3'h1;
        end
        if (byte_done) begin
          case (st_r)
            S_OP: begin
              if (busy_r && cmd != `OP_STAT_RD) begin
                st_r <= S_IGN;
              end else begin
                case (cmd)
                  `OP_SET_WL: begin
                    wel_r <= 1'b1;
                    st_r <= S_IGN;
                  end
                  `OP_CLR_WL: begin
                    wel_r <= 1'b0;
                    st_r <= S_IGN;
                  end
                  `OP_STAT_RD: begin
                    tx_r <= status;
                    st_r <= S_SRD;
                  end
                  `OP_STAT_WR: st_r <= wel_r ? S_SWR : S_IGN;
                  `OP_ARR_RD: begin
                    is_wr_r <= 1'b0;
                    st_r <= S_ADH;
                  end
                  `OP_ARR_WR: begin
                    is_wr_r <= 1'b1;
                    st_r <= wel_r ? S_ADH : S_IGN;
                  end
                  default: st_r <= S_IGN;
                endcase
              end
            end
            S_ADH: begin
              addr_r[`ADDR_W-1:8] <= rx_byte[`ADDR_W-9:0];
              st_r <= S_ADL;
            end
            S_ADL: begin
              pvalid_r <= {`PAGE_BYTES{1'b0}};
              if (is_wr_r) begin
                addr_r <= full_addr;
                st_r <= S_WR;
              end else begin
                tx_r <= mem[full_addr];
                addr_r <= full_addr + {{(`ADDR_W-1){1'b0}}, 1'b1};
                st_r <= S_RD;
              end
            end
            S_RD: begin
              tx_r <= mem[addr_r];
              addr_r <= addr_r + {{(`ADDR_W-1){1'b0}}, 1'b1};
            end
            S_SRD: tx_r <= status;
            S_WR: begin
              got_r <= 1'b1;
              if (!guarded(bg_r, addr_r))
                pvalid_r[pofs] <= 1'b1;
              addr_r[5:0] <= pofs + 6'h01;
            end
            S_SWR: begin
              new_stat_r <= rx_byte;
              got_r <= 1'b1;
            end
            default: st_r <= S_IGN;
          endcase
        end
        if (sck_fall && (st_r == S_RD || st_r == S_SRD)) begin
          so_o <= tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

endmodule

/* File: shared/eeprom_cmd_defines.vh */
// Constants of the serial EEPROM command and protection block.
// Included by the design file; definitions only.
`ifndef EEPROM_CMD_DEFINES_VH
`define EEPROM_CMD_DEFINES_VH

// Opcode low three bits, upper nibble zero, bit 3 ignored
`define OP_HI_NIBBLE 4'h0
`define OP_SET_WL 3'h6
`define OP_CLR_WL 3'h4
`define OP_STAT_RD 3'h5
`define OP_STAT_WR 3'h1
`define OP_ARR_RD 3'h3
`define OP_ARR_WR 3'h2
`define OP_INVALID 3'h0

// Status field positions
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1
`define ST_BG_LO_BIT 2
`define ST_BG_HI_BIT 3
`define ST_PPE_BIT 7
`define ST_BUSY_VALUE 8'hFF

// Reset values of the nonvolatile protection bits
`define RST_BG 2'h0
`define RST_PPE 1'h0

// Array geometry, 16K-byte variant
`define ADDR_W 14
`define MEM_DEPTH 16384
`define PAGE_BYTES 64

// Internal write cycle
`define T_WC_MS 5
`define CLK_MHZ 50
`define WC_CYCLES (`T_WC_MS * 1000 * `CLK_MHZ)

`endif

/* File: test/spi_eeprom_command_protect_asserts.sv */
// Port checker for the serial EEPROM slave.
// Sees only top ports; SPI pins are asynchronous to ref_clk_i.
`timescale 1ns/1ps
module spi_eeprom_command_protect_asserts #(
  parameter WC_CYCLES = 200
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire hold_n_i,
  input wire so_o,
  input wire so_oe_o
);
  reg sck_q;
  reg [3:0] since_fall;
  reg [3:0] since_rise;
  // Cycles since the last seen SCK edges, saturating
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q <= 1'h0;
      since_fall <= 4'hF;
      since_rise <= 4'hF;
    end else begin
      sck_q <= sck_i;
      since_fall <= (sck_q & ~sck_i) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
      since_rise <= (~sck_q & sck_i) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_desel_stays_off: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("SO driven while deselected");
  a_desel_drops_oe: assert property ($rose(cs_n_i) |-> ##[1:6] !so_oe_o)
    else $error("SO not released after select rise");
  a_pause_stays_off: assert property (!hold_n_i [*6] |-> !so_oe_o)
    else $error("SO driven during pause");
  a_pause_drops_oe: assert property ($fell(hold_n_i) |-> ##[1:6] !so_oe_o)
    else $error("SO not released at pause");
  a_reset_quiet: assert property ($rose(rst_n_i) |-> !so_oe_o [*4])
    else $error("SO driven after reset");
  a_oe_rise_sel: assert property ($rose(so_oe_o) |-> !cs_n_i && hold_n_i)
    else $error("SO enabled while not selected");
  a_oe_after_rise: assert property ($rose(so_oe_o) && $past(hold_n_i, 8) |-> since_rise < 4'h8)
    else $error("SO enabled away from a clock rise");
  a_so_moves_fall: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o) |-> since_fall < 4'h6)
    else $error("SO changed away from a clock fall");
endmodule

/* File: test/spi_master_model.sv */
// SPI master model, mode 0, for the EEPROM slave pins.
// Assumes clk_i is the bench clock; pins move at its falling edge.
`timescale 1ns/1ps
module spi_master_model (
  input wire clk_i,
  input wire so_i,
  output reg cs_n_o,
  output reg sck_o,
  output reg si_o,
  output reg hold_n_o
);
  integer half = 4;
  reg [7:0] rx_byte;
  event got;
  initial begin
    cs_n_o = 1'h1;
    sck_o = 1'h0;
    si_o = 1'h0;
    hold_n_o = 1'h1;
  end
  task wait_half;
    repeat (half) @(negedge clk_i);
  endtask
  task open_f;
    cs_n_o = 1'h0;
    wait_half;
  endtask
  // Release select in the low phase after the last bit
  task close_f;
    wait_half;
    cs_n_o = 1'h1;
    repeat (3) wait_half;
  endtask
  // Late sampling: the oversampled slave answers near the rise
  task xfer(input [7:0] tx, input chk, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      si_o = tx[i];
      wait_half;
      sck_o = 1'h1;
      wait_half;
      rx[i] = so_i;
      sck_o = 1'h0;
    end
    rx_byte = rx;
    if (chk) -> got;
  endtask
  // Pause only after SCK has settled low for a half period
  task pause(input integer n);
    wait_half;
    hold_n_o = 1'h0;
    repeat (n) begin
      wait_half;
      sck_o = 1'h1;
      wait_half;
      sck_o = 1'h0;
    end
    wait_half;
    hold_n_o = 1'h1;
    wait_half;
  endtask
endmodule

/* File: test/test_spi_eeprom_command_protect.sv */
// Bench for the serial EEPROM slave through the master model.
// Write cycle shortened by parameter; SO line resolved here.
`timescale 1ns/1ps
module test_spi_eeprom_command_protect;
  localparam WC = 200;
  reg ref_clk_i = 1'h0;
  reg rst_n_i = 1'h0;
  reg wp_n_i = 1'h1;
  wire cs_n, sck, si, hold_n, so, so_oe;
  // Released SO shows the inverse of its last value
  wire so_line = so_oe ? so : ~so;
  integer error_cnt = 0;
  integer tests_run = 0;
  integer seed = 8;
  integer i, j;
  reg [7:0] exp_q[$];
  reg [7:0] rx, d0, x;
  always #10 ref_clk_i = ~ref_clk_i;
  spi_master_model mst (.clk_i(ref_clk_i), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
    .hold_n_o(hold_n));
  spi_eeprom_command_protect #(.WC_CYCLES(WC)) spi_eeprom_command_protect_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i),
    .so_o(so), .so_oe_o(so_oe));
  ////////////////////////////////////////
  task check(input [7:0] seen, input [7:0] want);
    tests_run = tests_run + 1;
    if (seen !== want) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task summarize;
    error_cnt = error_cnt + exp_q.size();
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(mst.got) check(mst.rx_byte, exp_q.pop_front());
  task cmd(input [7:0] op);
    mst.open_f;
    mst.xfer(op, 1'h0, rx);
    mst.close_f;
  endtask
  task two(input [7:0] op, input [7:0] v, input chk);
    mst.open_f;
    mst.xfer(op, 1'h0, rx);
    mst.xfer(v, chk, rx);
    mst.close_f;
  endtask
  task status_expect(input [7:0] op, input [7:0] want);
    exp_q.push_back(want);
    two(op, 8'h00, 1'h1);
  endtask
  task acc(input [7:0] op, input [15:0] ad, input integer n, input [7:0] d, input chk);
    integer k;
    mst.open_f;
    mst.xfer(op, 1'h0, rx);
    mst.xfer(ad[15:8], 1'h0, rx);
    mst.xfer(ad[7:0], 1'h0, rx);
    if (op == 8'h03) mst.pause(3);
    for (k = 0; k < n; k = k + 1) mst.xfer(d + k[7:0], chk, rx);
    mst.close_f;
  endtask
  task wait_ready;
    exp_q.push_back(8'hFF);
    mst.open_f;
    mst.xfer(8'h05, 1'h0, rx);
    mst.xfer(8'h00, 1'h1, rx);
    i = 0;
    while (rx === 8'hFF && i < 40) begin
      mst.xfer(8'h00, 1'h0, rx);
      i = i + 1;
    end
    mst.close_f;
    if (rx === 8'hFF) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'h1;
    repeat (6) @(negedge ref_clk_i);
    status_expect(8'h0D, 8'h00);
    for (j = 0; j < 2; j = j + 1) begin
      wp_n_i = j[0];
      cmd({4'h0, j[0], 3'h6});
      status_expect(8'h05, 8'h02);
      cmd({4'h0, j[0], 3'h4});
      status_expect(8'h05, 8'h00);
    end
    wp_n_i = 1'h1;
    d0 = 8'($random(seed));
    x = 8'($random(seed));
    cmd(8'h06);
    acc(8'h02, 16'hC03E, 66, d0, 1'h0);
    wait_ready;
    status_expect(8'h05, 8'h00);
    cmd(8'h0E);
    acc(8'h0A, 16'h3FFF, 1, x, 1'h0);
    wait_ready;
    exp_q.push_back(d0 + 8'h40);
    exp_q.push_back(d0 + 8'h41);
    acc(8'h03, 16'h403E, 2, x, 1'h1);
    exp_q.push_back(x);
    exp_q.push_back(d0 + 8'h02);
    exp_q.push_back(d0 + 8'h03);
    acc(8'h0B, 16'h7FFF, 3, d0, 1'h1);
    cmd(8'h06);
    two(8'h09, 8'h84, 1'h0);
    wait_ready;
    status_expect(8'h05, 8'h84);
    cmd(8'h06);
    acc(8'h02, 16'h3000, 1, d0, 1'h0);
    status_expect(8'h05, 8'h86);
    wp_n_i = 1'h0;
    two(8'h01, 8'h00, 1'h0);
    cmd(8'h04);
    status_expect(8'h05, 8'h84);
    wp_n_i = 1'h1;
    cmd(8'h06);
    // Pin dips low only inside the status-write frame
    mst.open_f;
    mst.xfer(8'h01, 1'h0, rx);
    wp_n_i = 1'h0;
    mst.xfer(8'h00, 1'h0, rx);
    wp_n_i = 1'h1;
    mst.close_f;
    status_expect(8'h05, 8'h86);
    cmd(8'h06);
    two(8'h01, 8'h00, 1'h0);
    wait_ready;
    status_expect(8'h05, 8'h00);
    acc(8'h02, 16'h0005, 1, x, 1'h0);
    status_expect(8'h05, 8'h00);
    acc(8'h07, 16'h0005, 1, x, 1'h0);
    exp_q.push_back(d0 + 8'h07);
    acc(8'h03, 16'h0005, 1, x, 1'h1);
    summarize;
  end
endmodule
bind spi_eeprom_command_protect spi_eeprom_command_protect_asserts #(.WC_CYCLES(WC_CYCLES)) chk_inst (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .hold_n_i(hold_n_i),
  .so_o(so_o), .so_oe_o(so_oe_o));
